// ===== rtl/dier_map.svh
`ifndef DIER_MAP_SVH
`define DIER_MAP_SVH

`define DIER_NUM_EVT     32
`define DIER_NUM_CHIP    4
`define DIER_NUM_PERIPH  28
`define DIER_NUM_CORE    12
`define DIER_FIRST_CORE  4
`define DIER_NUM_COMB    4
`define DIER_EVT_SEL_W   5
`define DIER_COMB_SEL_W  2
`define DIER_RST_EVT     32'h0000_0000
`define DIER_RST_CORE    12'h000
`define DIER_RST_CHIP    4'h0

`endif

// ===== rtl/dier_pkg.sv
package dier_pkg;
  `include "dier_map.svh"

  typedef logic [`DIER_NUM_EVT-1:0]  dier_evt_vec_t;
  typedef logic [`DIER_NUM_CORE-1:0] dier_core_vec_t;
  typedef logic [`DIER_NUM_CHIP-1:0] dier_chip_vec_t;
  typedef logic [`DIER_NUM_COMB-1:0] dier_comb_vec_t;
  typedef dier_evt_vec_t [`DIER_NUM_COMB-1:0] dier_evt_arr_t;

  typedef struct packed {
    logic                        use_comb;
    logic [`DIER_EVT_SEL_W-1:0]  evt_sel;
    logic [`DIER_COMB_SEL_W-1:0] comb_sel;
  } dier_route_t;

  typedef dier_route_t [`DIER_NUM_CORE-1:0] dier_route_arr_t;

  typedef struct packed {
    dier_evt_vec_t flags;
  } dier_comb_state_t;

  typedef struct packed {
    dier_chip_vec_t chip_flag;
    dier_core_vec_t src_q;
    dier_core_vec_t pend;
  } dier_top_state_t;
endpackage

// ===== rtl/dier_combiner.sv
`timescale 1ns/1ns
`default_nettype none
`include "dier_map.svh"
module dier_combiner
  import dier_pkg::*;
(
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset,
  input  wire dier_evt_vec_t i_events,
  input  wire dier_evt_vec_t i_mask,
  input  wire dier_evt_vec_t i_clear,
  output dier_evt_vec_t      o_flags,
  output logic               o_combined
);
  dier_comb_state_t st;
  dier_comb_state_t next_st;

  // Every cycle an input is high counts as a fresh event, so a held
  // level re-sets its flag right after software clears it.
  always_comb begin
    next_st       = st;
    next_st.flags = (st.flags & ~i_clear) | (i_events & ~i_mask);
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st.flags <= `DIER_RST_EVT;
    end else begin
      st <= next_st;
    end
  end

  assign o_flags    = st.flags;
  // Mask also hides flags caught before the mask was set
  assign o_combined = |(st.flags & ~i_mask);

  a_level_refire: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    (i_events[5] && !i_mask[5] && i_clear[5]) |=> o_flags[5])
    else $error("Held combiner input did not re-set its flag");

  a_mask_blocks: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    (i_mask == `DIER_RST_EVT - 32'h0000_0001) |-> !o_combined)
    else $error("Fully masked combiner drove its output");

  a_masked_no_set: assert property (
    @(posedge i_sys_clk) disable iff (i_reset)
    (i_mask[1] && !o_flags[1]) |=> !o_flags[1])
    else $error("Masked event set a combiner flag");
endmodule
`default_nettype wire

// ===== rtl/dier_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "dier_map.svh"
// What this block does
// - The core sees twelve maskable interrupt inputs, numbered 4 to 15.
// - Each core input takes one system event directly or one combiner.
// - The combiner takes every high cycle of an input as a new event.
// - Chip-signal interrupts stay high while their flag stays set.
// - Core inputs take one interrupt per level assertion or pulse.
module dier_top
  import dier_pkg::*;
(
  input  wire logic            i_sys_clk,
  input  wire logic            i_reset,
  input  wire logic [`DIER_NUM_PERIPH-1:0] i_periph_events,
  input  wire dier_chip_vec_t  i_chip_set,
  input  wire dier_chip_vec_t  i_chip_clr,
  input  wire dier_route_arr_t i_route,
  input  wire dier_evt_arr_t   i_comb_mask,
  input  wire dier_evt_arr_t   i_comb_clr,
  input  wire dier_core_vec_t  i_core_ack,
  output dier_core_vec_t       o_core_hw_int,
  output dier_chip_vec_t       o_chip_flag,
  output dier_comb_vec_t       o_comb_active,
  output dier_evt_arr_t        o_comb_flags
);
  dier_top_state_t st;
  dier_top_state_t next_st;
  dier_evt_vec_t   sys_evt;
  dier_comb_vec_t  comb_out;
  dier_core_vec_t  src_now;

  function automatic logic route_pick(input dier_route_t    r,
                                      input dier_evt_vec_t  e,
                                      input dier_comb_vec_t c);
    route_pick = r.use_comb ? c[r.comb_sel] : e[r.evt_sel];
  endfunction

  // Chip-signal flags occupy the low event numbers
  assign sys_evt = {i_periph_events, st.chip_flag};

  for (genvar k = 0; k < `DIER_NUM_COMB; k++) begin : g_comb
    dier_combiner u_comb (
      .i_sys_clk  (i_sys_clk),
      .i_reset    (i_reset),
      .i_events   (sys_evt),
      .i_mask     (i_comb_mask[k]),
      .i_clear    (i_comb_clr[k]),
      .o_flags    (o_comb_flags[k]),
      .o_combined (comb_out[k])
    );
  end

  // Twelve routed sources, core inputs 4..15 map to index 0..11
  always_comb begin
    for (int j = 0; j < `DIER_NUM_CORE; j++) begin
      src_now[j] = route_pick(i_route[j], sys_evt, comb_out);
    end
  end

  always_comb begin
    next_st           = st;
    // Flag holds until cleared; set wins so no request is lost
    next_st.chip_flag = (st.chip_flag & ~i_chip_clr) | i_chip_set;
    next_st.src_q     = src_now;
    // Edge capture makes a long level count once, a pulse too
    next_st.pend      = (st.pend & ~i_core_ack)
                      | (src_now & ~st.src_q);
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st.chip_flag <= `DIER_RST_CHIP;
      st.src_q     <= `DIER_RST_CORE;
      st.pend      <= `DIER_RST_CORE;
    end else begin
      st <= next_st;
    end
  end

  assign o_core_hw_int = st.pend;
  assign o_chip_flag   = st.chip_flag;
  assign o_comb_active = comb_out;

  for (genvar j = 0; j < `DIER_NUM_CORE; j++) begin : g_chk
    a_rise_pends: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (src_now[j] && !st.src_q[j]) |=> o_core_hw_int[j])
      else $error("Source rise did not raise core interrupt");

    a_level_once: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_core_ack[j] && st.src_q[j] && src_now[j]) |=> !o_core_hw_int[j])
      else $error("Held level raised a second core interrupt");

    a_no_spurious: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (!o_core_hw_int[j] && !(src_now[j] && !st.src_q[j]))
        |=> !o_core_hw_int[j])
      else $error("Core interrupt raised with no source edge");

    a_route_src: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      !i_route[j].use_comb && $stable(i_route[j]) && $stable(sys_evt)
        |-> st.src_q[j] == $past(sys_evt[i_route[j].evt_sel]))
      else $error("Direct route did not follow its event");

    a_ack_clears: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_core_ack[j] && !(src_now[j] && !st.src_q[j]))
        |=> !o_core_hw_int[j])
      else $error("Acknowledged core interrupt stayed pending");

    a_pend_holds: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (o_core_hw_int[j] && !i_core_ack[j]) |=> o_core_hw_int[j])
      else $error("Core interrupt dropped without an acknowledge");

    a_comb_route: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      i_route[j].use_comb
        |-> (src_now[j] == o_comb_active[i_route[j].comb_sel]))
      else $error("Combined route did not follow its combiner");

    a_direct_now: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      !i_route[j].use_comb
        |-> (src_now[j] == sys_evt[i_route[j].evt_sel]))
      else $error("Direct route did not pick its event");

    a_comb_rise: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_route[j].use_comb && $rose(src_now[j])) |=> o_core_hw_int[j])
      else $error("Combined route rise did not raise core interrupt");

    a_chip_rise: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (!i_route[j].use_comb && (i_route[j].evt_sel < 5'h04)
        && $rose(src_now[j])) |=> o_core_hw_int[j])
      else $error("Direct chip-signal rise did not raise core interrupt");
  end

  for (genvar n = 0; n < `DIER_NUM_CHIP; n++) begin : g_chip_chk
    a_chip_set: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      i_chip_set[n] |=> o_chip_flag[n])
      else $error("Chip-signal set did not raise its flag");

    a_chip_wins: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_chip_set[n] && i_chip_clr[n]) |=> o_chip_flag[n])
      else $error("Chip-signal clear beat a set in the same cycle");

    a_chip_clear: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_chip_clr[n] && !i_chip_set[n]) |=> !o_chip_flag[n])
      else $error("Chip-signal clear did not drop its flag");

    a_chip_holds: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (o_chip_flag[n] && !i_chip_clr[n]) |=> o_chip_flag[n])
      else $error("Chip-signal level dropped without a clear");

    a_chip_idle: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (!o_chip_flag[n] && !i_chip_set[n]) |=> !o_chip_flag[n])
      else $error("Chip-signal flag rose without a set");

    a_chip_event: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      sys_evt[n] == o_chip_flag[n])
      else $error("Chip-signal flag missing from its event number");
  end

  for (genvar k = 0; k < `DIER_NUM_COMB; k++) begin : g_comb_chk
    a_active_flags: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      o_comb_active[k] |-> ((o_comb_flags[k] & ~i_comb_mask[k]) != '0))
      else $error("Combined output high with no unmasked flag");

    a_active_rises: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      ((sys_evt & ~i_comb_mask[k]) != '0) ##1 $stable(i_comb_mask[k])
        |-> o_comb_active[k])
      else $error("Unmasked event did not reach the combined output");

    for (genvar e = 0; e < `DIER_NUM_EVT; e++) begin : g_evt
      a_evt_sets: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        (sys_evt[e] && !i_comb_mask[k][e]) |=> o_comb_flags[k][e])
        else $error("Unmasked event did not set its combiner flag");

      a_evt_cleared: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_comb_clr[k][e] && !(sys_evt[e] && !i_comb_mask[k][e]))
          |=> !o_comb_flags[k][e])
        else $error("Combiner flag survived a clear with no event");

      a_evt_sticky: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        (o_comb_flags[k][e] && !i_comb_clr[k][e]) |=> o_comb_flags[k][e])
        else $error("Combiner flag dropped without a clear");

      a_evt_masked: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_comb_mask[k][e] && !o_comb_flags[k][e]) |=> !o_comb_flags[k][e])
        else $error("Masked event set its combiner flag");

      a_evt_idle: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        (!o_comb_flags[k][e] && !(sys_evt[e] && !i_comb_mask[k][e]))
          |=> !o_comb_flags[k][e])
        else $error("Combiner flag rose with no unmasked event");
    end
  end

  // No disable here: this one looks at the edge that ends reset
  a_reset_quiet: assert property (
    @(posedge i_sys_clk)
    $fell(i_reset) |-> (o_core_hw_int == '0) && (o_chip_flag == '0)
      && (o_comb_flags == '0) && (o_comb_active == '0))
    else $error("Outputs not quiet at reset release");
endmodule
`default_nettype wire

// ===== testbench/dier_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module dier_core_model
  import dier_pkg::*;
(
  input  wire logic           i_sys_clk,
  input  wire logic           i_reset,
  input  wire dier_core_vec_t i_int,
  output dier_core_vec_t      o_ack,
  output logic [15:0]         o_taken
);
  // Serves a pending input one cycle after seeing it, and counts it
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ack   <= '0;
      o_taken <= '0;
    end else begin
      o_ack   <= i_int & ~o_ack;
      o_taken <= o_taken + 16'($countones(i_int & ~o_ack));
    end
  end
endmodule
`default_nettype wire

// ===== testbench/dier_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "dier_map.svh"
module dier_top_tb;
  import dier_pkg::*;
  logic                        clk;
  logic                        rst;
  logic [`DIER_NUM_PERIPH-1:0] pev;
  dier_chip_vec_t              cset, cclr, chip;
  dier_route_arr_t             route;
  dier_evt_arr_t               mask, fclr, flags;
  dier_core_vec_t              ack, hw;
  dier_comb_vec_t              act;
  logic [15:0]                 taken;
  int                          mismatches, checks_done;

  dier_top dut_u (.i_sys_clk(clk), .i_reset(rst), .i_periph_events(pev),
    .i_chip_set(cset), .i_chip_clr(cclr), .i_route(route),
    .i_comb_mask(mask), .i_comb_clr(fclr), .i_core_ack(ack),
    .o_core_hw_int(hw), .o_chip_flag(chip), .o_comb_active(act),
    .o_comb_flags(flags));
  dier_core_model core_u (.i_sys_clk(clk), .i_reset(rst), .i_int(hw),
    .o_ack(ack), .o_taken(taken));

  task automatic report_and_stop();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for the core to have served n interrupts
  task automatic wait_taken(input logic [15:0] n);
    for (int k = 0; k < 20 && taken !== n; k++) @(negedge clk);
    if (taken !== n) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  // Chip flag 0 routed straight to core input 4
  task automatic chip_direct();
    @(posedge clk) cset <= 4'h1;
    @(posedge clk) cset <= 4'h0;
    wait_taken(16'h1);
    repeat (6) @(negedge clk);
    cmp(chip, 4'h1);
    cmp(taken, 16'h1);
    @(posedge clk) cclr <= 4'h1;
    @(posedge clk) cclr <= 4'h0;
    @(negedge clk);
    cmp(chip, 4'h0);
  endtask

  // Held event 5 and masked chip flag 1 on combiner 0, core input 5
  task automatic comb_level();
    @(posedge clk) begin
      cset <= 4'h2;
      pev <= 28'h2;
    end
    @(posedge clk) cset <= 4'h0;
    wait_taken(16'h2);
    @(posedge clk) fclr[0] <= 32'h20;
    @(posedge clk) fclr[0] <= '0;
    @(negedge clk);
    cmp(flags[0][5], 1'b1);
    cmp(flags[0][1], 1'b0);
    repeat (6) @(negedge clk);
    cmp(taken, 16'h2);
    @(posedge clk) pev <= '0;
    @(posedge clk) fclr[0] <= 32'h20;
    @(posedge clk) fclr[0] <= '0;
    @(negedge clk);
    cmp(act, 4'h0);
    cmp(hw, 12'h000);
  endtask

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rst, pev, cset, cclr, route, mask, fclr} = '0;
    rst = 1;
    mismatches = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    rst <= 0;
    route[0] <= '{1'b0, 5'h00, 2'h0};
    route[1] <= '{1'b1, 5'h00, 2'h0};
    mask[0] <= ~32'h20;
    // Spare core inputs sit on fully masked combiners so they stay quiet
    for (int j = 2; j < `DIER_NUM_CORE; j++) begin
      route[j] <= '{1'b1, 5'h00, 2'h3};
    end
    mask[1] <= '1;
    mask[2] <= '1;
    mask[3] <= '1;
    chip_direct();
    comb_level();
    report_and_stop();
  end
endmodule
`default_nettype wire
